//--- swl_pkg.sv
// Package of constants and types for the single-wire bit frame link.
// ****************************************************************
// Function
// - Bytes travel most significant bit first.
// - Ninth frame carries acknowledge or no-acknowledge.
// - Upper address nibble is a command opcode.
// - Frame timing starts at falling edge.
// - Long low drains energy, device restarts.
// - Device stretches discovery low to ack time.
// - Device leaves reset in high speed.
// - Busy device ignores frames; only a discharge low is still seen.
// - Frame lengths may vary within limits.
// - Sample between one and zero lows.
// - Zero means ack, one means nack.
// - High-speed discovery ack 8 to 24 us.
// ****************************************************************
package swl_pkg;

  // ****************************************************************
  // Timing in nanoseconds and derived cycle counts at 125 MHz.
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  // Sample points lie past the longest one-low and before the shortest
  // zero-low time of each speed mode.
  localparam int HS_SAMPLE_NS = 4000;
  localparam int SS_SAMPLE_NS = 16000;
  // Discovery acknowledge held inside the 8 to 24 us window.
  localparam int DISC_ACK_NS = 16000;
  // Reset low times: a low this long is taken as a reset.
  localparam int HS_RESET_NS = 48000;
  localparam int SS_RESET_NS = 480000;
  // Start condition high time per speed mode.
  localparam int HS_START_NS = 150000;
  localparam int SS_START_NS = 600000;
  // Discharge low time.
  localparam int DISCHARGE_NS = 150000;

  localparam int HS_SAMPLE_CYC = HS_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int SS_SAMPLE_CYC = SS_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int DISC_ACK_CYC = DISC_ACK_NS / CLK_PERIOD_NS;
  localparam int HS_RESET_CYC = HS_RESET_NS / CLK_PERIOD_NS;
  localparam int SS_RESET_CYC = SS_RESET_NS / CLK_PERIOD_NS;
  localparam int HS_START_CYC = HS_START_NS / CLK_PERIOD_NS;
  localparam int SS_START_CYC = SS_START_NS / CLK_PERIOD_NS;
  localparam int DISCHARGE_CYC = DISCHARGE_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Field layout of the device address byte.
  // ****************************************************************
  localparam int OPCODE_MSB = 7;
  localparam int OPCODE_LSB = 4;
  localparam int BYTE_BITS = 8;
  localparam int CNT_W = 24;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;

  // Receive state machine.
  typedef enum logic [2:0] {
    SWL_ST_WAIT_START = 3'b000,
    SWL_ST_DISC_WAIT  = 3'b001,
    SWL_ST_DISC_ACK   = 3'b010,
    SWL_ST_IDLE       = 3'b011,
    SWL_ST_LOW        = 3'b100,
    SWL_ST_HIGH       = 3'b101,
    SWL_ST_BUSY       = 3'b110
  } swl_state_e;

  // Received byte as it leaves the block.
  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] rest;
    logic       first;
  } swl_byte_s;

endpackage

//--- swl_link.sv
// Bit frame receiver of the single-wire link, device side.
`timescale 1ns/1ps
module swl_link
  import swl_pkg::*;
#(
  parameter int RESET_CYC     = HS_RESET_CYC,
  parameter int SS_RST_CYC    = SS_RESET_CYC,
  parameter int START_CYC     = HS_START_CYC,
  parameter int SS_STRT_CYC   = SS_START_CYC,
  parameter int DSCHG_CYC     = DISCHARGE_CYC
) (
  // Clock and reset.
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  // Single-wire line, open drain.
  input  wire logic       i_sio,
  output logic            o_sio,
  output logic            o_sio_oe_n,
  // Device core control.
  input  wire logic       i_busy,
  input  wire logic       i_std_speed,
  input  wire logic       i_set_speed,
  input  wire logic       i_ack_n,
  // Received byte stream.
  output swl_byte_s       o_byte,
  output logic            o_byte_valid,
  input  wire logic       i_byte_ready,
  output logic            o_ack_done,
  output logic            o_ack_bit,
  output logic            o_std_mode,
  output logic            o_start,
  output logic            o_reset_seen
);

  // ****************************************************************
  // Line synchroniser.
  // ****************************************************************
  logic sio_meta_reg;   // First stage, read only by the second.
  logic sio_sync_reg;   // Usable line level.
  logic sio_prev_reg;   // Previous level for edge detect.

  // The line crosses in from the pin through two flops.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      sio_meta_reg <= 1'b1;
      sio_sync_reg <= 1'b1;
      sio_prev_reg <= 1'b1;
    end else begin
      sio_meta_reg <= i_sio;
      sio_sync_reg <= sio_meta_reg;
      sio_prev_reg <= sio_sync_reg;
    end
  end

  // ****************************************************************
  // State and counters.
  // ****************************************************************
  swl_state_e       state_reg, state_next;  // Receive state.
  logic [CNT_W-1:0] cnt_reg, cnt_next;      // Time since last edge.
  logic [3:0]       bit_reg, bit_next;      // Bits of this byte.
  logic [7:0]       shift_reg, shift_next;  // Byte being assembled.
  logic             first_reg, first_next;  // Next byte is address.
  logic             std_reg, std_next;      // Standard speed active.
  logic             drive_reg, drive_next;  // Pulling the line low.
  logic             sampled_reg, sampled_next; // Frame already sampled.
  logic [CNT_W-1:0] frm_reg, frm_next;      // Time since frame start.
  logic             pend_reg, pend_next;    // Full byte awaits a slot.

  wire fall     = sio_prev_reg & ~sio_sync_reg;
  // The frame timer runs from the falling edge only, so a one whose low
  // ended early is still sampled at the fixed point.
  wire sample_t = std_reg ? (frm_reg == CNT_W'(SS_SAMPLE_CYC))
                          : (frm_reg == CNT_W'(HS_SAMPLE_CYC));
  wire in_frame = (state_reg == SWL_ST_LOW) || (state_reg == SWL_ST_HIGH);
  wire rst_low  = ~sio_sync_reg &
                  (cnt_reg >= (std_reg ? CNT_W'(SS_RST_CYC)
                                       : CNT_W'(RESET_CYC)));
  wire dsc_low  = ~sio_sync_reg & (cnt_reg >= CNT_W'(DSCHG_CYC));
  wire start_hi = sio_sync_reg &
                  (cnt_reg >= (std_reg ? CNT_W'(SS_STRT_CYC)
                                       : CNT_W'(START_CYC)));
  wire cnt_sat  = &cnt_reg;
  wire ack_slot = (bit_reg == 4'(BYTE_BITS));

  // ****************************************************************
  // Two-entry output buffer.
  // ****************************************************************
  swl_byte_s buf_mem_reg [2];   // Storage, indexed by pointer.
  logic      wr_ptr_reg;        // Write index.
  logic      rd_ptr_reg;        // Read index.
  logic [1:0] fill_reg;         // Words held.
  logic      push;              // A finished byte to store.
  wire       buf_full  = (fill_reg == 2'h2);
  wire       buf_empty = (fill_reg == 2'h0);
  wire       pop       = ~buf_empty & i_byte_ready;

  assign o_byte       = buf_mem_reg[rd_ptr_reg];
  assign o_byte_valid = ~buf_empty;

  // Buffer pointers; a byte that finds the buffer full waits in the
  // shift register, but only until the next byte's first bit lands.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fill_reg   <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      fill_reg <= fill_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Buffer storage has no reset; the fill count guards reads.
  always_ff @(posedge i_clock) begin
    if (push) buf_mem_reg[wr_ptr_reg] <= '{shift_reg[OPCODE_MSB:OPCODE_LSB],
                                          shift_reg[3:0], first_reg};
  end

  // ****************************************************************
  // Frame decode.
  // ****************************************************************
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_sat ? cnt_reg : cnt_reg + CNT_W'(1);
    bit_next     = bit_reg;
    shift_next   = shift_reg;
    first_next   = first_reg;
    std_next     = i_set_speed ? i_std_speed : std_reg;
    drive_next   = 1'b0;
    sampled_next = sampled_reg;
    frm_next     = (&frm_reg) ? frm_reg : frm_reg + CNT_W'(1);
    pend_next    = pend_reg;
    push         = 1'b0;
    o_ack_done   = 1'b0;
    o_start      = 1'b0;
    o_reset_seen = 1'b0;
    if (sio_prev_reg != sio_sync_reg) cnt_next = '0;
    if (fall) frm_next = '0;
    // Completed byte goes to the buffer when a slot is free.
    if (pend_reg && !buf_full) begin
      push       = 1'b1;
      pend_next  = 1'b0;
      first_next = 1'b0;
    end
    // Sample once per frame, whether or not the host has let go yet.
    if (in_frame && sample_t && !sampled_reg) begin
      sampled_next = 1'b1;
      if (ack_slot) begin
        o_ack_done = 1'b1;
        bit_next   = BIT_CNT_RST;
      end else begin
        shift_next = {shift_reg[6:0], sio_sync_reg};
        bit_next   = bit_reg + 4'h1;
        if (bit_reg == 4'(BYTE_BITS - 1)) pend_next = 1'b1;
      end
    end
    unique case (state_reg)
      // After power-up the device waits for a discovery request.
      SWL_ST_WAIT_START, SWL_ST_DISC_WAIT: begin
        if (fall) begin
          state_next = SWL_ST_DISC_ACK;
          cnt_next   = '0;
          drive_next = 1'b1;
        end
      end
      // Hold the line low until the acknowledge time runs out.
      SWL_ST_DISC_ACK: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (cnt_reg < CNT_W'(DISC_ACK_CYC - 1)) begin
          drive_next = 1'b1;
        end else begin
          state_next = SWL_ST_IDLE;
          cnt_next   = '0;
        end
      end
      // Line high between frames; a long high after a frame is a start condition.
      SWL_ST_IDLE, SWL_ST_HIGH: begin
        if (fall) begin
          state_next   = SWL_ST_LOW;
          sampled_next = 1'b0;
        end else if (start_hi && (bit_reg != BIT_CNT_RST ||
                                  state_reg == SWL_ST_HIGH)) begin
          bit_next   = BIT_CNT_RST;
          first_next = 1'b1;
          state_next = SWL_ST_IDLE;
          o_start    = 1'b1;
        end
      end
      // Line low inside a frame; a long low is a reset.
      SWL_ST_LOW: begin
        if (rst_low) begin
          o_reset_seen = 1'b1;
          state_next   = SWL_ST_DISC_WAIT;
          bit_next     = BIT_CNT_RST;
          pend_next    = 1'b0;
          first_next   = 1'b1;
          std_next     = 1'b0;
        end else if (sio_sync_reg) begin
          state_next = SWL_ST_HIGH;
        end
      end
      // Core busy: frames are not timed; a discharge or the core finishing ends it.
      SWL_ST_BUSY: begin
        if (dsc_low) begin
          o_reset_seen = 1'b1;
          state_next   = SWL_ST_DISC_WAIT;
          bit_next     = BIT_CNT_RST;
          pend_next    = 1'b0;
          first_next   = 1'b1;
          std_next     = 1'b0;
        end else if (!i_busy) begin
          // The core finished; listen for the next start again.
          state_next = SWL_ST_IDLE;
        end
      end
      default: state_next = SWL_ST_WAIT_START;
    endcase
    // A busy core mutes framing; a device waiting for discovery after a
    // reset has lost power, so a stale busy level does not hold it.
    if (i_busy && (in_frame || state_reg == SWL_ST_IDLE)) begin
      state_next = SWL_ST_BUSY;
      bit_next   = BIT_CNT_RST;
      pend_next  = 1'b0;
      first_next = 1'b1;
    end
  end

  // ****************************************************************
  // State registers.
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_reg   <= SWL_ST_WAIT_START;
      cnt_reg     <= '0;
      bit_reg     <= BIT_CNT_RST;
      shift_reg   <= 8'h00;
      first_reg   <= 1'b1;
      std_reg     <= 1'b0;
      drive_reg   <= 1'b0;
      sampled_reg <= 1'b0;
      frm_reg     <= '0;
      pend_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      bit_reg     <= bit_next;
      shift_reg   <= shift_next;
      first_reg   <= first_next;
      std_reg     <= std_next;
      drive_reg   <= drive_next;
      sampled_reg <= sampled_next;
      frm_reg     <= frm_next;
      pend_reg    <= pend_next;
    end
  end

  // The line is only ever pulled low, never driven high.
  assign o_sio      = 1'b0;
  assign o_sio_oe_n = ~drive_reg;
  assign o_ack_bit  = sio_sync_reg;
  assign o_std_mode = std_reg;

  // Acknowledge from the core is taken in the output frame logic,
  // which lies outside this block; the input is kept for that hookup.
  wire unused_ack = i_ack_n;

endmodule // swl_link

//--- swl_link_properties.sv
// Concurrent checks on the ports of the single-wire bit frame receiver.
`timescale 1ns/1ps
module swl_link_properties
  import swl_pkg::*;
(
  // Clock and reset.
  input wire logic      i_clock,
  input wire logic      i_nrst,
  // Line and core control.
  input wire logic      i_sio,
  input wire logic      o_sio,
  input wire logic      o_sio_oe_n,
  input wire logic      i_busy,
  input wire logic      i_std_speed,
  input wire logic      i_set_speed,
  // Byte stream and status.
  input wire swl_byte_s o_byte,
  input wire logic      o_byte_valid,
  input wire logic      i_byte_ready,
  input wire logic      o_ack_done,
  input wire logic      o_ack_bit,
  input wire logic      o_std_mode,
  input wire logic      o_reset_seen
);
  // ****************************************************************
  // Helper logic and assertions.
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  // Cycles the device has held the line low; cleared when it lets go.
  logic [11:0] low_cnt_reg;
  always_ff @(posedge i_clock) begin
    if (!i_nrst || o_sio_oe_n) low_cnt_reg <= 12'h000;
    else low_cnt_reg <= low_cnt_reg + 12'h001;
  end

  sio_low_only_a: assert property (o_sio == 1'b0)
    else $error("device drives the line high");
  ack_cause_a: assert property ($fell(o_sio_oe_n) |-> !$past(i_sio))
    else $error("device pulled the line without a host edge");
  ack_len_a: assert property ($rose(o_sio_oe_n) |->
    low_cnt_reg >= 12'h3de && low_cnt_reg <= 12'hbae)
    else $error("discovery acknowledge length out of window");
  ack_bit_a: assert property (o_ack_done |-> o_ack_bit == $past(i_sio, 4))
    else $error("ninth frame level wrong");
  busy_quiet_a: assert property (i_busy && $past(i_busy) |-> !o_ack_done)
    else $error("frame decoded while busy");
  busy_mute_a: assert property (i_busy && o_sio_oe_n |=> o_sio_oe_n)
    else $error("line pulled while busy");
  buf_hold_a: assert property (o_byte_valid && !i_byte_ready |=>
    o_byte_valid && $stable(o_byte))
    else $error("stalled byte lost or changed");
  speed_load_a: assert property (i_set_speed |=>
    o_std_mode == $past(i_std_speed))
    else $error("speed mode not loaded");
  reset_hs_a: assert property ($rose(i_nrst) |-> !o_std_mode)
    else $error("not in high speed after reset");
  restart_hs_a: assert property (o_reset_seen |-> ##[0:2] !o_std_mode)
    else $error("reset low left standard speed");
endmodule // swl_link_properties

bind swl_link swl_link_properties u_props (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_sio(i_sio), .o_sio(o_sio),
  .o_sio_oe_n(o_sio_oe_n), .i_busy(i_busy), .i_std_speed(i_std_speed),
  .i_set_speed(i_set_speed), .o_byte(o_byte), .o_byte_valid(o_byte_valid),
  .i_byte_ready(i_byte_ready), .o_ack_done(o_ack_done),
  .o_ack_bit(o_ack_bit), .o_std_mode(o_std_mode),
  .o_reset_seen(o_reset_seen));

//--- swl_host.sv
// Host controller model that pulls the single-wire line in frames.
`timescale 1ns/1ps
module swl_host (
  // Clock and line.
  input  wire logic i_clock,
  input  wire logic i_line,
  output logic      o_pull
);
  // ****************************************************************
  // High-speed frame timing in clock cycles.
  // ****************************************************************
  localparam int ZERO_LOW = 800;  // Low of 6.4 us for a zero.
  localparam int ONE_LOW  = 150;  // Low of 1.2 us for a one.
  // Frame of 8.8 us leaves the client its recovery time after a zero.
  localparam int FRAME    = 1100; // Frame well inside its limits.

  initial o_pull = 1'b0;

  // Pull low for n cycles, then release to the pull-up.
  task automatic low(input int n, input int hi);
    @(negedge i_clock) o_pull = 1'b1;
    repeat (n) @(negedge i_clock);
    o_pull = 1'b0;
    repeat (hi) @(negedge i_clock);
  endtask

  // One input frame; frames follow with no gap.
  task automatic bit_frame(input logic b);
    low(b ? ONE_LOW : ZERO_LOW, FRAME - (b ? ONE_LOW : ZERO_LOW));
  endtask

  // Eight bits MSB first, then the ninth frame.
  task automatic send_byte(input logic [7:0] d, input logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_frame(d[i]);
    end
    bit_frame(a);
  endtask

  // Recovery, short request, strobe at 4 us.
  task automatic discover(output logic seen);
    repeat (1000) @(negedge i_clock);
    low(150, 350);
    seen = ~i_line;
    repeat (1600) @(negedge i_clock);
  endtask

  // Line left high long enough to form a start condition.
  task automatic start();
    repeat (1300) @(negedge i_clock);
  endtask
endmodule // swl_host

//--- swl_link_tb.sv
// Self-checking testbench of the single-wire bit frame receiver.
`timescale 1ns/1ps
module swl_link_tb;
  import swl_pkg::*;
  // ****************************************************************
  // Signals, pull-up and instances.
  // ****************************************************************
  logic      i_clock, i_nrst, i_busy, i_std_speed, i_set_speed;
  logic      i_byte_ready, host_pull, o_sio, o_sio_oe_n, seen;
  logic      o_byte_valid, o_ack_done, o_ack_bit, o_std_mode;
  logic      o_start, o_reset_seen, ack_last, ack_n;
  swl_byte_s o_byte;
  int        err_count, total_checks, rst_cnt, ack_cnt, cycles, st_cnt;
  // The pull-up wins unless some party pulls the line low.
  wire sio_line = !(host_pull || (!o_sio_oe_n && !o_sio));

  // Counts are shortened but kept above the longest frame low and high;
  // the standard-speed start count is unused and keeps its default.
  swl_link #(.RESET_CYC(1200), .SS_RST_CYC(1200), .START_CYC(1200),
    .DSCHG_CYC(1500)) DUT (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_sio(sio_line), .o_sio(o_sio),
    .o_sio_oe_n(o_sio_oe_n), .i_busy(i_busy), .i_std_speed(i_std_speed),
    .i_set_speed(i_set_speed), .i_ack_n(ack_n), .o_byte(o_byte),
    .o_byte_valid(o_byte_valid), .i_byte_ready(i_byte_ready),
    .o_ack_done(o_ack_done), .o_ack_bit(o_ack_bit), .o_std_mode(o_std_mode),
    .o_start(o_start), .o_reset_seen(o_reset_seen));
  swl_host host (.i_clock(i_clock), .i_line(sio_line), .o_pull(host_pull));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  // Compare and count; unknowns never match.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Pulse counters and a hang limit well past the planned run.
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (o_reset_seen === 1'b1) rst_cnt <= rst_cnt + 1;
    if (o_start === 1'b1) st_cnt <= st_cnt + 1;
    if (o_ack_done === 1'b1) begin
      ack_cnt <= ack_cnt + 1;
      ack_last <= o_ack_bit;
    end
    if (cycles == 90000) begin
      err_count++;
      summarize();
    end
  end

  // Check the head byte, then pop it with a one-cycle ready.
  task automatic pop(input swl_byte_s e);
    check(16'(o_byte), 16'(e));
    @(negedge i_clock) i_byte_ready = 1'b1;
    @(negedge i_clock) i_byte_ready = 1'b0;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_disc();
    host.discover(seen);
    check(16'(seen), 16'h0001);
    check(16'(o_std_mode), 16'h0000);
    check(16'(o_byte_valid), 16'h0000);
  endtask

  // Two bytes land while the reader stalls; both must survive.
  task automatic t_stall();
    int a0 = ack_cnt;
    host.start();
    host.send_byte(8'hd5, 1'b0);
    check(16'(ack_last), 16'h0000);
    host.send_byte(8'h3a, 1'b1);
    check(16'(ack_last), 16'h0001);
    check(16'(ack_cnt - a0), 16'h0002);
    pop('{4'hd, 4'h5, 1'b1});
    pop('{4'h3, 4'ha, 1'b0});
    check(16'(o_byte_valid), 16'h0000);
  endtask

  // A reset low in mid-byte throws away the partial byte.
  task automatic t_abort();
    int r0 = rst_cnt;
    int s0 = st_cnt;
    host.start();
    check(16'(st_cnt - s0), 16'h0001);
    repeat (4) host.bit_frame(1'b1);
    host.low(1300, 10);
    check(16'(rst_cnt - r0), 16'h0001);
    t_disc();
    host.start();
    host.send_byte(8'h96, 1'b0);
    pop('{4'h9, 4'h6, 1'b1});
  endtask

  // A busy core ignores frames until the line is discharged.
  task automatic t_busy();
    int a0 = ack_cnt;
    int r0 = rst_cnt;
    @(negedge i_clock) i_busy = 1'b1;
    host.send_byte(8'h00, 1'b0);
    check(16'(ack_cnt - a0), 16'h0000);
    check(16'(o_byte_valid), 16'h0000);
    host.low(1600, 10);
    i_busy = 1'b0;
    check(16'(rst_cnt - r0), 16'h0001);
    t_disc();
  endtask

  // Standard speed is loaded, then a reset low returns to high speed.
  task automatic t_speed();
    @(negedge i_clock) i_std_speed = 1'b1;
    i_set_speed = 1'b1;
    @(negedge i_clock) i_set_speed = 1'b0;
    check(16'(o_std_mode), 16'h0001);
    host.low(1300, 10);
    t_disc();
  endtask

  initial begin
    {i_nrst, i_busy, i_std_speed, i_set_speed, i_byte_ready} = 5'h00;
    {err_count, total_checks, rst_cnt, ack_cnt, cycles, st_cnt} = '0;
    ack_last = 1'b1;
    ack_n = 1'b1;
    repeat (10) @(negedge i_clock);
    i_nrst = 1'b1;
    t_disc();
    t_stall();
    t_abort();
    t_busy();
    t_speed();
    summarize();
  end
endmodule // swl_link_tb
